// ---- rtl/pscc_regs.sv ----
// top: symbol error counter and special control register for one port
// assumes straps are stable while reset is low and caught at the first edge after release
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
module pscc_regs
  import pscc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          soft_rst,
  input  wire pscc_bus_t     bus,
  input  wire pscc_rx_t      rx,
  input  wire logic          ten_mode,
  input  wire pscc_strap_t   strap,
  output logic [15:0]        rdata,
  output pscc_xo_mode_t      xo_mode,
  output logic               heartbeat_test_disable,
  output logic               far_end_fault_gen,
  output logic               far_end_fault_detect_en,
  output logic               auto_crossover_strap_readback
);

  typedef struct packed {
    logic          strap_pend;
    logic          auto_strap;
    logic          manual_strap;
    logic          fiber;
    logic          ovr_sel;
    logic          auto_en;
    logic          man_state;
    logic          hb_dis;
    logic          fef_en;
    logic [15:0]   rdata;
    pscc_xo_mode_t xo;
  } pscc_state_t;

  pscc_state_t   st_reg;
  pscc_state_t   st_next;
  logic [15:0]   cnt;
  logic [15:0]   spec_rd;
  pscc_xo_mode_t xo_dec;

  // ==========================================================
  // submodules
  pscc_err_count #(
    .WIDTH (16)
  ) u_cnt (
    .clk      (clk),
    .rst_n    (rst_n),
    .rx       (rx),
    .ten_mode (ten_mode),
    .count    (cnt)
  );

  pscc_xo_decode u_xo (
    .ovr_sel      (st_reg.ovr_sel),
    .auto_en      (st_reg.auto_en),
    .man_state    (st_reg.man_state),
    .auto_strap   (st_reg.auto_strap),
    .manual_strap (st_reg.manual_strap),
    .mode         (xo_dec)
  );

  // ==========================================================
  // read view
  always_comb begin
    spec_rd                     = 16'h0000;                           // RULE15
    spec_rd[PSCC_OVR_SEL_BIT]   = st_reg.ovr_sel;
    spec_rd[PSCC_AUTO_EN_BIT]   = st_reg.auto_en;
    spec_rd[PSCC_MAN_STATE_BIT] = st_reg.man_state;
    spec_rd[PSCC_HB_DIS_BIT]    = st_reg.hb_dis;
    spec_rd[PSCC_FEF_EN_BIT]    = st_reg.fef_en;
  end

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.xo = xo_dec;
    st_next.rdata = 16'h0000;
    // straps caught one edge after reset release, never under reset
    if (st_reg.strap_pend) begin
      st_next.strap_pend   = 1'b0;
      st_next.auto_strap   = strap.auto_strap;                        // RULE9
      st_next.manual_strap = strap.manual_strap;
      st_next.fiber        = strap.fiber_mode;
      st_next.fef_en       = strap.fiber_mode;                        // RULE13
    end
    // soft reset spares the persistent bits
    if (soft_rst) begin
      st_next.ovr_sel = 1'b0;                                         // RULE14
      // next-state fiber, so a soft reset at the strap edge still sees the strap
      st_next.fef_en  = st_next.fiber;                                // RULE13
    end else if (bus.wr && bus.addr == PSCC_SPEC_CTL_IDX) begin
      st_next.ovr_sel   = bus.wdata[PSCC_OVR_SEL_BIT];                // RULE6
      st_next.auto_en   = bus.wdata[PSCC_AUTO_EN_BIT];
      st_next.man_state = bus.wdata[PSCC_MAN_STATE_BIT];
      st_next.hb_dis    = bus.wdata[PSCC_HB_DIS_BIT];                 // RULE11
      st_next.fef_en    = bus.wdata[PSCC_FEF_EN_BIT];                 // RULE12
    end
    if (bus.rd) begin
      case (bus.addr)
        PSCC_SYM_ERR_IDX:  st_next.rdata = cnt;                       // RULE4
        PSCC_SPEC_CTL_IDX: st_next.rdata = spec_rd;
        PSCC_HARDWARE_CONFIG_IDX:   st_next.rdata = {15'h0000, st_reg.auto_strap}; // RULE9
        default:           st_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.strap_pend <= 1'b1;
      st_reg.hb_dis     <= 1'b0;                                      // RULE11
      st_reg.xo         <= PSCC_XO_MANUAL_STRAIGHT;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign rdata                         = st_reg.rdata;
  assign xo_mode                       = st_reg.xo;
  assign heartbeat_test_disable        = st_reg.hb_dis;
  assign far_end_fault_gen             = st_reg.fef_en;               // RULE12
  assign far_end_fault_detect_en       = st_reg.fef_en;               // RULE12
  assign auto_crossover_strap_readback = st_reg.auto_strap;

  // ==========================================================
  // checks
  ovr_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.ovr_sel && !st_reg.auto_en && st_reg.man_state)
      |=> xo_mode == PSCC_XO_MANUAL_CROSS) // RULE7
    else $error("override crossover not applied");
  strap_auto_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_reg.ovr_sel && st_reg.auto_strap && !st_reg.strap_pend)
      |=> xo_mode == PSCC_XO_AUTO) // RULE8
    else $error("auto strap ignored");
  sel_default_a: assert property (@(posedge clk)
    !rst_n |=> !st_reg.ovr_sel && !st_reg.hb_dis) // RULE6
    else $error("control defaults wrong");
  soft_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_rst |=> $stable(st_reg.hb_dis) && $stable(st_reg.auto_en)) // RULE14
    else $error("persistent bit lost on soft reset");
  fef_fiber_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.strap_pend && strap.fiber_mode && !(bus.wr && bus.addr == PSCC_SPEC_CTL_IDX))
      |=> far_end_fault_gen) // RULE13
    else $error("fiber far-end fault default missing");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && bus.addr == PSCC_SPEC_CTL_IDX) |=> (rdata & ~PSCC_SPEC_WMASK) == 16'h0000) // RULE15
    else $error("reserved bits not zero");
  cnt_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && bus.addr == PSCC_SYM_ERR_IDX) |=> rdata == $past(cnt)) // RULE4
    else $error("counter read wrong");
  hb_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !soft_rst && bus.addr == PSCC_SPEC_CTL_IDX)
      |=> heartbeat_test_disable == $past(bus.wdata[PSCC_HB_DIS_BIT])) // RULE11
    else $error("heartbeat disable write lost");

endmodule : pscc_regs

// ---- rtl/pscc_pkg.sv ----
// constants, field layout and carrier types of the symbol error / crossover register pair
// assumes one clock, synchronous active-low reset, plain register port with 16-bit data
//
// Behaviour
// (RULE1) count invalid 100TX symbols, idle included
// (RULE2) at most one count per packet
// (RULE3) counter wraps to zero past maximum
// (RULE4) counter resets zero, read-only, read-safe
// (RULE5) no counting in 10BASE-T mode
// (RULE6) override select: straps or register bits
// (RULE7) register bits decode: manual, crossover, auto; auto_en with man_state set decodes to PSCC_XO_RESERVED here
// (RULE8) straps decode: auto strap wins, manual
// (RULE9) latched auto strap readable in config
// (RULE10) software avoids auto crossover in fiber
// (RULE11) heartbeat disable bit defaults zero
// (RULE12) far-end fault enable gates generate/detect
// (RULE13) far-end fault enable resets one in fiber
// (RULE14) persistent bits survive per-PHY soft reset
// (RULE15) reserved bits read zero, ignore writes
package pscc_pkg;

  // ==========================================================
  // register map
  localparam logic [4:0]  PSCC_SYM_ERR_IDX  = 5'h1A;
  localparam logic [4:0]  PSCC_SPEC_CTL_IDX = 5'h1B;
  localparam logic [4:0]  PSCC_HARDWARE_CONFIG_IDX   = 5'h1F;
  localparam logic [15:0] PSCC_CNT_RESET    = 16'h0000;

  // ==========================================================
  // field positions
  localparam int PSCC_OVR_SEL_BIT   = 15;
  localparam int PSCC_AUTO_EN_BIT   = 14;
  localparam int PSCC_MAN_STATE_BIT = 13;
  localparam int PSCC_HB_DIS_BIT    = 11;
  localparam int PSCC_FEF_EN_BIT    = 5;
  localparam int PSCC_STRAP_RB_BIT  = 0;
  localparam logic [15:0] PSCC_SPEC_WMASK = 16'hE820;

  // ==========================================================
  // crossover modes
  typedef enum logic [1:0] {
    PSCC_XO_MANUAL_STRAIGHT = 2'b00,
    PSCC_XO_MANUAL_CROSS    = 2'b01,
    PSCC_XO_AUTO            = 2'b10,
    PSCC_XO_RESERVED        = 2'b11
  } pscc_xo_mode_t;

  typedef struct packed {
    logic        valid;
    logic        symbol_err;
    logic        in_packet;
  } pscc_rx_t;

  typedef struct packed {
    logic        auto_strap;
    logic        manual_strap;
    logic        fiber_mode;
  } pscc_strap_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pscc_bus_t;

endpackage : pscc_pkg

// ---- rtl/pscc_err_count.sv ----
// symbol error counter with once-per-packet limiting
// assumes decoder flags are synchronous to clk
`timescale 1ns/10ps
module pscc_err_count
  import pscc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire pscc_rx_t         rx,
  input  wire logic             ten_mode,
  output logic [WIDTH-1:0]      count
);

  // the increment builds a WIDTH-1 zero replication, so one bit cannot work
  if (WIDTH < 2) begin : g_width_check
    $error("counter width below two bits");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             pkt_hit;
  } pscc_cnt_state_t;

  pscc_cnt_state_t st_reg;
  pscc_cnt_state_t st_next;
  logic            hit;

  // ==========================================================
  // counting
  always_comb begin
    st_next = st_reg;
    hit     = rx.valid && rx.symbol_err && !ten_mode;                 // RULE1 RULE5
    if (hit && !(rx.in_packet && st_reg.pkt_hit)) begin               // RULE2
      st_next.cnt = st_reg.cnt + {{(WIDTH-1){1'b0}}, 1'b1};           // RULE3
    end
    if (!rx.in_packet) begin
      st_next.pkt_hit = 1'b0;
    end else if (hit) begin
      st_next.pkt_hit = 1'b1;                                         // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;                                                   // RULE4
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.cnt;

  // ==========================================================
  // checks
  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.cnt != $past(st_reg.cnt) |-> st_reg.cnt == $past(st_reg.cnt) + 1'b1) // RULE3
    else $error("counter moved by other than one");
  ten_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ten_mode |=> $stable(st_reg.cnt)) // RULE5
    else $error("counter moved in 10BASE-T");
  pkt_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx.in_packet && st_reg.pkt_hit) |=> $stable(st_reg.cnt)) // RULE2
    else $error("second count within one packet");
  idle_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx.valid && rx.symbol_err && !ten_mode && !rx.in_packet)
      |=> st_reg.cnt == $past(st_reg.cnt) + 1'b1) // RULE1
    else $error("idle symbol error not counted");

endmodule : pscc_err_count

// ---- rtl/pscc_xo_decode.sv ----
// crossover mode selection from straps or register bits
// assumes strap levels already latched and stable
`timescale 1ns/10ps
module pscc_xo_decode
  import pscc_pkg::*;
(
  input  wire logic          ovr_sel,
  input  wire logic          auto_en,
  input  wire logic          man_state,
  input  wire logic          auto_strap,
  input  wire logic          manual_strap,
  output pscc_xo_mode_t      mode
);

  always_comb begin
    if (ovr_sel) begin
      mode = pscc_xo_mode_t'({auto_en, man_state});                  // RULE6 RULE7
    end else if (auto_strap) begin
      mode = PSCC_XO_AUTO;                                            // RULE8
    end else begin
      mode = manual_strap ? PSCC_XO_MANUAL_CROSS : PSCC_XO_MANUAL_STRAIGHT; // RULE8
    end
  end

endmodule : pscc_xo_decode

// ---- tb/pscc_regs_tb.sv ----
// testbench: random and corner stimulus for the symbol error counter and special control
// assumes pscc_regs top, one 200 MHz clock, synchronous active-low reset held 16 cycles
`timescale 1ns/10ps
module pscc_regs_tb;
  import pscc_pkg::*;
  logic          clk         = 1'b0;
  logic          rst_n       = 1'b0;
  logic          soft_rst    = 1'b0;
  pscc_bus_t     bus         = '0;
  pscc_rx_t      rx          = '0;
  logic          ten_mode    = 1'b0;
  pscc_strap_t   strap       = '0;
  logic [15:0]   rdata;
  pscc_xo_mode_t xo_mode;
  logic          hb_dis;
  logic          fef_gen;
  logic          fef_det;
  logic          strap_rb;
  int            miscompares = 0;
  int            checks      = 0;
  logic [15:0]   v;
  logic [15:0]   cnt;
  logic          e;

  pscc_regs pscc_regs_i (
    .clk                           (clk),
    .rst_n                         (rst_n),
    .soft_rst                      (soft_rst),
    .bus                           (bus),
    .rx                            (rx),
    .ten_mode                      (ten_mode),
    .strap                         (strap),
    .rdata                         (rdata),
    .xo_mode                       (xo_mode),
    .heartbeat_test_disable        (hb_dis),
    .far_end_fault_gen             (fef_gen),
    .far_end_fault_detect_en       (fef_det),
    .auto_crossover_strap_readback (strap_rb)
  );

  always #2.5 clk = ~clk;

  // ==========================================================
  // helpers
  task automatic test_done;
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // extra edge: xo_mode lands one cycle after the register bits
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic do_reset(input pscc_strap_t s);
    @(posedge clk);
    strap <= s;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
  endtask : do_reset

  // trailing idle cycle ends any packet
  task automatic sym(input logic err, input logic pkt, input int k);
    repeat (k) begin
      @(posedge clk);
      rx <= '{1'b1, err, pkt};
    end
    @(posedge clk);
    rx <= '0;
  endtask : sym

  function automatic pscc_xo_mode_t exp_xo(logic o, logic ae, logic ms, pscc_strap_t s);
    if (o) return pscc_xo_mode_t'({ae, ms});
    if (s.auto_strap) return PSCC_XO_AUTO;
    return s.manual_strap ? PSCC_XO_MANUAL_CROSS : PSCC_XO_MANUAL_STRAIGHT;
  endfunction : exp_xo

  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'h0534C73D));
    for (int s = 0; s < 8; s++) begin
      do_reset(pscc_strap_t'(s[2:0]));
      rd(PSCC_SPEC_CTL_IDX, v);
      chk("spec reset", {10'h000, strap.fiber_mode, 5'h00}, v);
      chk("fef reset", {2{strap.fiber_mode}}, {fef_gen, fef_det});
      chk("xo strap", exp_xo(1'b0, 1'b0, 1'b0, strap), xo_mode);
      rd(PSCC_HARDWARE_CONFIG_IDX, v);
      chk("strap rb", {15'h0000, strap.auto_strap}, v & 16'h0001);
      chk("strap rb out", {15'h0000, strap.auto_strap}, {15'h0000, strap_rb});
      rd(PSCC_SYM_ERR_IDX, v);
      chk("cnt reset", 16'h0000, v);
    end
    do_reset(pscc_strap_t'(3'b110));
    for (int i = 0; i < 4; i++) begin
      wr(PSCC_SPEC_CTL_IDX, {1'b1, i[1:0], 13'h0000});
      chk("xo ovr", exp_xo(1'b1, i[1], i[0], strap), xo_mode);
    end
    repeat (24) begin
      v = 16'($urandom);
      v[14] = v[14] & ~strap.fiber_mode;
      wr(PSCC_SPEC_CTL_IDX, v);
      rd(PSCC_SPEC_CTL_IDX, cnt);
      chk("spec rw", v & PSCC_SPEC_WMASK, cnt);
      chk("hb out", {15'h0000, v[11]}, {15'h0000, hb_dis});
      chk("fef out", {2{v[5]}}, {fef_gen, fef_det});
      chk("xo rnd", exp_xo(v[15], v[14], v[13], strap), xo_mode);
    end
    do_reset(pscc_strap_t'(3'b001));
    wr(PSCC_SPEC_CTL_IDX, 16'hA800);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    rd(PSCC_SPEC_CTL_IDX, v);
    chk("soft rst", 16'h2820, v);
    do_reset('0);
    rd(PSCC_SPEC_CTL_IDX, v);
    chk("phy rst", 16'h0000, v);
    cnt = 16'h0000;
    repeat (40) begin
      e = 1'($urandom);
      sym(e, 1'b0, 1);
      cnt += {15'h0000, e};
    end
    sym(1'b1, 1'b1, 5);
    sym(1'b0, 1'b0, 1);
    sym(1'b1, 1'b1, 2);
    sym(1'b0, 1'b0, 1);
    cnt += 16'h0002;
    ten_mode <= 1'b1;
    sym(1'b1, 1'b0, 4);
    ten_mode <= 1'b0;
    wr(PSCC_SYM_ERR_IDX, 16'h1234);
    rd(PSCC_SYM_ERR_IDX, v);
    chk("cnt", cnt, v);
    rd(PSCC_SYM_ERR_IDX, v);
    chk("cnt reread", cnt, v);
    sym(1'b1, 1'b0, 65536);
    rd(PSCC_SYM_ERR_IDX, v);
    chk("cnt wrap", cnt, v);
    test_done();
  end

  // roughly 66k cycles expected; 90k cycles means a hang
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : pscc_regs_tb
